// ==== logic/spl_loader.sv ====
/*
 * Start-up and swap parameter loader. Decides the load path at start-up,
 * drives a copy engine (storage/card to working memory, write-back) and
 * keeps the confirmation and download-failure faults.
 * Assumes srst stands for a power cycle; the confirmation fault survives it
 * through confirmPendingNv, which the surrounding logic keeps in storage.
 */
`timescale 1ns/100ps
// Functional notes
// - policy 0 no card load, 1 load once next start, 2 load every start.
// - after a one-time load the device rewrites the policy to 0.
// - start-up without card copies storage parameters into working memory.
// - no card with policy 1 or 2 starts from storage, no fault.
// - autoload reads the fixed image; missing image raises autoload-failed fault.
// - successful autoload raises confirmation-pending fault until confirmed.
// - accept 0, input signal or panel key clears confirmation-pending fault.
// - accept 2 after a clone discards card parameters, reloads from storage.
// - writing discard also acknowledges confirmation-pending fault on standard units.
// - failed download reverts to storage set and raises a failure fault.
// - failed download from other unit reports first failing parameter number.
// - start-up download failure faults stay until the next power cycle.
// - swap at power-on loads card or storage and raises confirmation fault.
// - after acknowledge of card swap, write back to storage unless accept 2.
// - power module swap while running is detected, reloads, raises confirmation.
// - failed swap download reverts, raises confirmation plus one failure fault.
// - confirmation fault survives power cycle; failure faults cleared only by it.
// - card set from a different unit variant counts as invalid.
// - swap without card keeps only storage parameters.
module spl_loader (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// register port
	input  wire spl_pkg::spl_bus_s      bus,
	output logic [31:0]                 rdata,
	// pins from the card slot and swap detection
	input  wire logic                   cardPresent,
	input  wire logic                   swapAtPowerOn,
	input  wire logic                   hotSwapEvent,
	// confirmation sources and unit variant
	input  wire logic                   confirmInput,
	input  wire logic                   panelKey,
	input  wire logic                   failSafeUnit,
	input  wire logic                   acceptTestDone,
	input  wire logic [7:0]             commissioningStage,
	input  wire logic                   passwordOk,
	input  wire logic                   confirmPendingNv,
	// copy engine
	output spl_pkg::spl_copy_s          copyReq,
	input  wire spl_pkg::spl_copy_ans_s copyAns,
	// fault outputs and start-up done flag
	output logic [3:0]                  faults,
	output logic                        startupDone
);
	import spl_pkg::*;

	// ***********************************************
	// state
	// ***********************************************
	typedef struct packed {
		spl_state_e  state;
		logic [2:0]  cardSync;
		logic [2:0]  swapSync;
		logic [2:0]  hotSync;
		logic [2:0]  keySync;
		logic [2:0]  inSync;
		logic [1:0]  warm;
		logic        cardLatched;
		logic        swapLatched;
		logic        fromCard;
		logic        cloned;
		logic [1:0]  policy;
		logic [1:0]  accept;
		logic [3:0]  flt;
		logic [15:0] failParam;
		logic        done;
		logic        wbPending;
		spl_copy_s   req;
		logic [31:0] rdata;
		logic        nvSeen;
	} spl_reg_s;

	spl_reg_s cur_ff;
	spl_reg_s nxt_cur;

	function automatic logic isConfirm(input logic failSafe, input logic [7:0] stage,
		input logic pwd, input logic test);
		isConfirm = !failSafe || (test && pwd && stage == SPL_STAGE_CONFIRM);
	endfunction

	function automatic logic isDiscard(input logic failSafe, input logic [7:0] stage,
		input logic pwd, input logic test);
		isDiscard = !failSafe || (test && pwd && stage == SPL_STAGE_DISCARD);
	endfunction

	logic ackReq;
	logic discardReq;
	logic keyRise;
	logic inRise;
	logic wrAccept;

	// ***********************************************
	// next state
	// ***********************************************
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.cardSync = {cur_ff.cardSync[1:0], cardPresent};
		nxt_cur.swapSync = {cur_ff.swapSync[1:0], swapAtPowerOn};
		nxt_cur.hotSync  = {cur_ff.hotSync[1:0], hotSwapEvent};
		nxt_cur.keySync  = {cur_ff.keySync[1:0], panelKey};
		nxt_cur.inSync   = {cur_ff.inSync[1:0], confirmInput};
		nxt_cur.req      = '0;
		// edges taken between the second and third stage only
		keyRise  = cur_ff.keySync[1] && !cur_ff.keySync[2];
		inRise   = cur_ff.inSync[1] && !cur_ff.inSync[2];
		wrAccept = bus.wr && bus.addr == SPL_REG_ACCEPT;

		// register writes
		if (bus.wr && bus.addr == SPL_REG_POLICY) begin
			nxt_cur.policy = bus.wdata[1:0];
		end
		if (wrAccept) begin
			nxt_cur.accept = bus.wdata[1:0];
		end

		ackReq = cur_ff.flt[SPL_FLT_CONFIRM] && isConfirm(failSafeUnit,
			commissioningStage, passwordOk, acceptTestDone) &&
			((wrAccept && bus.wdata[1:0] == SPL_ACCEPT_OK) ||
			inRise || keyRise);
		discardReq = wrAccept && bus.wdata[1:0] == SPL_ACCEPT_DISCARD &&
			cur_ff.cloned && isDiscard(failSafeUnit, commissioningStage,
			passwordOk, acceptTestDone);

		case (cur_ff.state)
			SPL_IDLE: begin
				// wait until the pin synchronisers hold the real levels
				nxt_cur.warm = cur_ff.warm + 2'h1;
				if (cur_ff.warm == SPL_SYNC_WAIT) begin
					nxt_cur.state = SPL_SAMPLE;
				end
			end
			SPL_SAMPLE: begin
				// path frozen for the whole start-up
				nxt_cur.cardLatched = cur_ff.cardSync[2];
				nxt_cur.swapLatched = cur_ff.swapSync[2];
				nxt_cur.flt[SPL_FLT_CONFIRM] = confirmPendingNv;
				if (cur_ff.cardSync[2] && (cur_ff.swapSync[2] ||
					cur_ff.policy != SPL_POLICY_NONE)) begin
					nxt_cur.state    = SPL_CARD_LOAD;
					nxt_cur.req.cardToRam = 1'b1;
				end else begin
					nxt_cur.state  = SPL_NV_LOAD;
					nxt_cur.req.nvToRam = 1'b1;
					if (cur_ff.swapSync[2]) begin
						nxt_cur.flt[SPL_FLT_CONFIRM] = 1'b1;
					end
				end
			end
			SPL_CARD_LOAD: begin
				if (copyAns.done) begin
					nxt_cur.flt[SPL_FLT_CONFIRM] = 1'b1;
					if (copyAns.ok) begin
						nxt_cur.fromCard = 1'b1;
						nxt_cur.cloned   = 1'b1;
						nxt_cur.wbPending = cur_ff.swapLatched;
						if (cur_ff.policy == SPL_POLICY_ONCE) begin
							nxt_cur.policy = SPL_POLICY_NONE;
						end
						nxt_cur.state = SPL_RUN;
					end else begin
						if (copyAns.incompatible) begin
							nxt_cur.flt[SPL_FLT_INCOMP] = 1'b1;
							nxt_cur.failParam = copyAns.failParam;
						end else if (copyAns.imageMissing || !cur_ff.swapLatched) begin
							nxt_cur.flt[SPL_FLT_AUTOLD] = 1'b1;
						end else begin
							nxt_cur.flt[SPL_FLT_SWAPDL] = 1'b1;
						end
						if (!cur_ff.swapLatched) begin
							nxt_cur.flt[SPL_FLT_CONFIRM] = cur_ff.flt[SPL_FLT_CONFIRM];
						end
						nxt_cur.state = SPL_NV_LOAD;
						nxt_cur.req.nvToRam = 1'b1;
					end
				end
			end
			SPL_NV_LOAD: begin
				if (copyAns.done) begin
					nxt_cur.state = SPL_RUN;
				end
			end
			SPL_RUN: begin
				nxt_cur.done = 1'b1;
				if (cur_ff.hotSync[2] == 1'b0 && cur_ff.hotSync[1]) begin
					// live power module swap
					nxt_cur.swapLatched = 1'b1;
					nxt_cur.cardLatched = cur_ff.cardSync[2];
					nxt_cur.done = 1'b0;
					if (cur_ff.cardSync[2]) begin
						nxt_cur.state = SPL_CARD_LOAD;
						nxt_cur.req.cardToRam = 1'b1;
					end else begin
						nxt_cur.state = SPL_NV_LOAD;
						nxt_cur.req.nvToRam = 1'b1;
						nxt_cur.flt[SPL_FLT_CONFIRM] = 1'b1;
					end
				end else if (discardReq) begin
					nxt_cur.flt[SPL_FLT_CONFIRM] = 1'b0;
					nxt_cur.fromCard  = 1'b0;
					nxt_cur.wbPending = 1'b0;
					nxt_cur.state = SPL_DISCARD;
					nxt_cur.req.nvToRam = 1'b1;
				end else if (ackReq) begin
					nxt_cur.flt[SPL_FLT_CONFIRM] = 1'b0;
					if (cur_ff.wbPending) begin
						nxt_cur.state = SPL_WRITEBACK;
						nxt_cur.req.ramToNv = 1'b1;
					end
				end
			end
			SPL_WRITEBACK: begin
				if (copyAns.done) begin
					nxt_cur.wbPending = 1'b0;
					nxt_cur.state = SPL_RUN;
				end
			end
			SPL_DISCARD: begin
				if (copyAns.done) begin
					nxt_cur.state = SPL_RUN;
				end
			end
			default: begin
				nxt_cur.state = SPL_IDLE;
			end
		endcase

		// read port
		nxt_cur.rdata = 32'h0000_0000;
		if (bus.rd) begin
			case (bus.addr)
				SPL_REG_POLICY:  nxt_cur.rdata = {30'h0, cur_ff.policy};
				SPL_REG_ACCEPT:  nxt_cur.rdata = {30'h0, cur_ff.accept};
				SPL_REG_FAULTS:  nxt_cur.rdata = {28'h0, cur_ff.flt};
				SPL_REG_FAILPAR: nxt_cur.rdata = {16'h0, cur_ff.failParam};
				SPL_REG_STATUS:  nxt_cur.rdata = {27'h0, cur_ff.fromCard, cur_ff.cloned,
					cur_ff.swapLatched, cur_ff.cardLatched, cur_ff.done};
				default:         nxt_cur.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ***********************************************
	// registers
	// ***********************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cur_ff <= '0;
			cur_ff.state  <= SPL_IDLE;
			cur_ff.policy <= SPL_POLICY_RESET;
			cur_ff.failParam <= SPL_FAILPAR_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign rdata       = cur_ff.rdata;
	assign copyReq     = cur_ff.req;
	assign faults      = cur_ff.flt;
	assign startupDone = cur_ff.done;

endmodule

// ==== logic/spl_pkg.sv ====
/*
 * Package of the start-up parameter loader: register map, policy and
 * accept-select codes, fault bit positions, state enum and carrier structs.
 * Assumes a single clock domain and a plain strobe register port.
 */
package spl_pkg;

	// ***********************************************
	// register map (byte offsets)
	// ***********************************************
	localparam logic [7:0] SPL_REG_POLICY  = 8'h00;
	localparam logic [7:0] SPL_REG_ACCEPT  = 8'h04;
	localparam logic [7:0] SPL_REG_FAULTS  = 8'h08;
	localparam logic [7:0] SPL_REG_FAILPAR = 8'h0C;
	localparam logic [7:0] SPL_REG_STATUS  = 8'h10;
	localparam logic [7:0] SPL_REG_CONFIRM = 8'h14;

	// ***********************************************
	// policy and accept-select codes
	// ***********************************************
	localparam logic [1:0] SPL_POLICY_NONE   = 2'h0;
	localparam logic [1:0] SPL_POLICY_ONCE   = 2'h1;
	localparam logic [1:0] SPL_POLICY_ALWAYS = 2'h2;
	localparam logic [1:0] SPL_POLICY_RESET  = 2'h1;
	localparam logic [1:0] SPL_ACCEPT_OK      = 2'h0;
	localparam logic [1:0] SPL_ACCEPT_DISCARD = 2'h2;

	// ***********************************************
	// fault register bit positions
	// ***********************************************
	localparam int SPL_FLT_CONFIRM = 0;
	localparam int SPL_FLT_AUTOLD  = 1;
	localparam int SPL_FLT_SWAPDL  = 2;
	localparam int SPL_FLT_INCOMP  = 3;

	// status bit positions
	localparam int SPL_ST_DONE   = 0;
	localparam int SPL_ST_CARD   = 1;
	localparam int SPL_ST_SWAP   = 2;
	localparam int SPL_ST_CLONED = 3;
	localparam int SPL_ST_FROMCD = 4;

	localparam logic [15:0] SPL_FAILPAR_RESET = 16'h0000;

	// commissioning stages of the fail-safe confirm and discard procedures
	localparam logic [7:0] SPL_STAGE_CONFIRM = 8'h1E;
	localparam logic [7:0] SPL_STAGE_DISCARD = 8'h5F;

	// last idle count before sampling; idle lasts one cycle longer, so the pin synchronisers are filled
	localparam logic [1:0] SPL_SYNC_WAIT = 2'h3;

	// ***********************************************
	// types
	// ***********************************************
	typedef enum logic [3:0] {
		SPL_IDLE,
		SPL_SAMPLE,
		SPL_NV_LOAD,
		SPL_CARD_LOAD,
		SPL_RUN,
		SPL_WRITEBACK,
		SPL_DISCARD
	} spl_state_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} spl_bus_s;

	// card/storage copy engine request and answer
	typedef struct packed {
		logic nvToRam;
		logic cardToRam;
		logic ramToNv;
	} spl_copy_s;

	typedef struct packed {
		logic        done;
		logic        ok;
		logic        imageMissing;
		logic        incompatible;
		logic [15:0] failParam;
	} spl_copy_ans_s;

endpackage

// ==== test/spl_card_model.sv ====
/* Far-side model: copy engine with the card slot.
   Assumes the loader keeps one copy request open at a time. */
`timescale 1ns/100ps
module spl_card_model (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	// request and answer
	input  wire spl_pkg::spl_copy_s     copyReq,
	output spl_pkg::spl_copy_ans_s      copyAns,
	// answer shaping
	input  wire logic [1:0]             mode,
	input  wire logic [4:0]             delay,
	input  wire logic [15:0]            badParam
);
	import spl_pkg::*;
	logic [5:0]  cnt;
	logic        fromCard;
	logic [18:0] noise;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt      <= 6'h0;
			noise    <= 19'h0;
			fromCard <= 1'b0;
			copyAns  <= '0;
		end else begin
			// answer fields carry junk outside the done pulse
			noise   <= noise + 19'h1357;
			copyAns <= {1'b0, noise};
			if (|copyReq) begin
				cnt      <= {1'b0, delay} + 6'h1;
				fromCard <= copyReq.cardToRam;
			end else if (cnt != 6'h0) begin
				cnt <= cnt - 6'h1;
				if (cnt == 6'h1)
					copyAns <= '{1'b1, !fromCard || mode == 2'h0, fromCard && mode == 2'h1,
						fromCard && mode == 2'h2, badParam};
			end
		end
	end
endmodule

// ==== test/spl_loader_chk.sv ====
/* Port checker of the start-up loader.
   Assumes cardPresent stays steady during a start-up. */
`timescale 1ns/100ps
module spl_loader_chk (
	// clock and reset
	input wire logic                   clk_sys,
	input wire logic                   srst,
	// observed ports
	input wire spl_pkg::spl_bus_s      bus,
	input wire logic [31:0]            rdata,
	input wire logic                   cardPresent,
	input wire spl_pkg::spl_copy_s     copyReq,
	input wire spl_pkg::spl_copy_ans_s copyAns,
	input wire logic [3:0]             faults,
	input wire logic                   startupDone
);
	import spl_pkg::*;
	logic sawDone_ff;
	logic sawMiss_ff;
	logic sawInc_ff;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sawDone_ff <= 1'b0;
			sawMiss_ff <= 1'b0;
			sawInc_ff  <= 1'b0;
		end else if (copyAns.done) begin
			sawDone_ff <= 1'b1;
			sawMiss_ff <= sawMiss_ff | copyAns.imageMissing;
			sawInc_ff  <= sawInc_ff | copyAns.incompatible;
		end
	end
	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("rdata not zero without read");
	flt_read_a: assert property (bus.rd && bus.addr == SPL_REG_FAULTS |=>
		rdata[3:0] == $past(faults)) else $error("fault read mismatch");
	fail_hold_a: assert property ((faults[3:1] & $past(faults[3:1])) == $past(faults[3:1]))
		else $error("failure fault cleared");
	one_fail_a: assert property ($onehot0(faults[3:1]))
		else $error("several failure faults");
	card_req_a: assert property (copyReq.cardToRam |-> cardPresent)
		else $error("card load without card");
	req_pulse_a: assert property (|copyReq |-> $onehot(copyReq) ##1 copyReq == 3'h0)
		else $error("copy request not single pulse");
	miss_cause_a: assert property (faults[1] |-> sawMiss_ff)
		else $error("autoload fault without missing image");
	inc_cause_a: assert property (faults[3] |-> sawInc_ff)
		else $error("incompatible fault without cause");
	conf_cause_a: assert property ($rose(faults[0]) |-> (|copyReq) || $past(copyAns.done))
		else $error("confirm fault without load");
	done_cause_a: assert property (startupDone |-> sawDone_ff)
		else $error("start-up done without load");
	cover property (faults[0]);
	cover property (faults[1]);
	cover property (copyReq.ramToNv);
endmodule
bind spl_loader spl_loader_chk chk (.clk_sys(clk_sys), .srst(srst), .bus(bus),
	.rdata(rdata), .cardPresent(cardPresent), .copyReq(copyReq), .copyAns(copyAns),
	.faults(faults), .startupDone(startupDone));

// ==== test/tb_spl_loader.sv ====
/* Self-checking bench of the start-up loader.
   Assumes the card model answers every copy request. */
`timescale 1ns/100ps
module tb_spl_loader;
	import spl_pkg::*;
	logic          clk_sys = 1'b0;
	logic          srst = 1'b1;
	spl_bus_s      bus = '0;
	logic          cardPresent = 1'b0;
	logic          swapAtPowerOn = 1'b0;
	logic          hotSwapEvent = 1'b0;
	logic          failSafeUnit = 1'b0;
	logic          acceptTestDone = 1'b0;
	logic [7:0]    commissioningStage = 8'h0;
	logic          passwordOk = 1'b0;
	logic          confirmInput = 1'b0;
	logic          panelKey = 1'b0;
	logic          confirmPendingNv = 1'b0;
	logic [1:0]    mode = 2'h0;
	logic [4:0]    delay = 5'h1;
	logic [15:0]   badParam = 16'h0;
	logic [31:0]   rdata;
	logic [31:0]   rv;
	logic [31:0]   seed = 32'h3FDB4288;
	spl_copy_s     copyReq;
	spl_copy_s     seenReq;
	spl_copy_ans_s copyAns;
	logic [3:0]    faults;
	logic          startupDone;
	int            nvCnt;
	int            base;
	int            failures = 0;
	int            checks = 0;
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		seenReq <= srst ? 3'h0 : seenReq | copyReq;
		nvCnt   <= srst ? 0 : nvCnt + int'(copyReq.nvToRam);
	end
	spl_loader dut (.clk_sys(clk_sys), .srst(srst), .bus(bus), .rdata(rdata),
		.cardPresent(cardPresent), .swapAtPowerOn(swapAtPowerOn),
		.hotSwapEvent(hotSwapEvent), .confirmInput(confirmInput), .panelKey(panelKey),
		.failSafeUnit(failSafeUnit), .acceptTestDone(acceptTestDone),
		.commissioningStage(commissioningStage), .passwordOk(passwordOk),
		.confirmPendingNv(confirmPendingNv), .copyReq(copyReq), .copyAns(copyAns),
		.faults(faults), .startupDone(startupDone));
	spl_card_model card (.clk_sys(clk_sys), .srst(srst), .copyReq(copyReq),
		.copyAns(copyAns), .mode(mode), .delay(delay), .badParam(badParam));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// faults left after a start-up with card c, swap s and card answer m, for m 0 to 2 and, with a card, swap only at m 0
	function automatic logic [31:0] expF(input logic c, input logic s, input logic [1:0] m);
		if (!c || m == 2'h0)
			return {31'h0, s | c};
		return m == 2'h1 ? 32'h2 : 32'h8;
	endfunction
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic boot(input logic c, input logic s, input logic [1:0] m);
		int n;
		@(posedge clk_sys);
		rv = xs();
		srst          <= 1'b1;
		cardPresent   <= c;
		swapAtPowerOn <= s;
		mode          <= m;
		delay         <= rv[4:0];
		badParam      <= rv[23:8];
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		n = 0;
		while (startupDone !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			n++;
		end
		chk(32'(startupDone), 32'h1);
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic settle(input logic [31:0] exp);
		repeat (60) @(posedge clk_sys);
		chk(32'(faults), exp);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		boot(1'b0, 1'b0, 2'h0);
		chk(32'(faults), expF(1'b0, 1'b0, 2'h0));
		chk(32'(seenReq), 32'h4);
		rdc(SPL_REG_POLICY, 32'h1);
		rdc({2'h1, rv[3:0], 2'h0}, 32'h0);
		for (int m = 0; m < 3; m++) begin
			boot(1'b1, 1'b0, m[1:0]);
			rdc(SPL_REG_FAULTS, expF(1'b1, 1'b0, m[1:0]));
			if (m == 0)
				rdc(SPL_REG_POLICY, 32'h0);
			if (m == 2)
				rdc(SPL_REG_FAILPAR, 32'(badParam));
			wr(SPL_REG_ACCEPT, 32'h0);
			settle(expF(1'b1, 1'b0, m[1:0]) & 32'hE);
		end
		boot(1'b1, 1'b0, 2'h0);
		base = nvCnt;
		wr(SPL_REG_ACCEPT, 32'h2);
		settle(32'h0);
		chk(32'(nvCnt > base), 32'h1);
		boot(1'b1, 1'b1, 2'h0);
		chk(32'(faults), expF(1'b1, 1'b1, 2'h0));
		wr(SPL_REG_ACCEPT, 32'h0);
		settle(32'h0);
		chk(32'(seenReq.ramToNv), 32'h1);
		boot(1'b0, 1'b1, 2'h0);
		chk(32'(faults), expF(1'b0, 1'b1, 2'h0));
		chk(32'(seenReq.cardToRam), 32'h0);
		confirmInput <= 1'b1;
		repeat (4) @(posedge clk_sys);
		confirmInput <= 1'b0;
		settle(32'h0);
		hotSwapEvent <= 1'b1;
		repeat (4) @(posedge clk_sys);
		hotSwapEvent <= 1'b0;
		settle(32'h1);
		panelKey <= 1'b1;
		repeat (4) @(posedge clk_sys);
		panelKey <= 1'b0;
		settle(32'h0);
		failSafeUnit <= 1'b1;
		boot(1'b1, 1'b0, 2'h0);
		wr(SPL_REG_ACCEPT, 32'h0);
		settle(32'h1);
		commissioningStage <= 8'h1E;
		passwordOk         <= 1'b1;
		acceptTestDone     <= 1'b1;
		wr(SPL_REG_ACCEPT, 32'h0);
		settle(32'h0);
		base = nvCnt;
		commissioningStage <= 8'h5F;
		wr(SPL_REG_ACCEPT, 32'h2);
		settle(32'h0);
		chk(32'(nvCnt > base), 32'h1);
		confirmPendingNv <= 1'b1;
		failSafeUnit     <= 1'b0;
		boot(1'b0, 1'b0, 2'h0);
		chk(32'(faults), 32'h1);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		complete_run();
	end
endmodule
